// ===== hdl/iopc_cfg.svh
// Constants for the interrupt option and low-power control block
`ifndef IOPC_CFG_SVH
`define IOPC_CFG_SVH
`define IOPC_ADDR_MODE_CFG  8'hc8
`define IOPC_ADDR_CORE_CTL  8'hcc
`define IOPC_ADDR_STATUS    8'hd0
`define IOPC_ADDR_STAB      8'hd4
`define IOPC_MODE_RESET     8'h00
`define IOPC_BIT_LEVEL      6
`define IOPC_BIT_EDGE_POL   5
`define IOPC_BIT_GLOBAL_EN  4
`define IOPC_MODE_USED_MASK 8'h70
`define IOPC_STAB_DEFAULT   16'h0100
`define IOPC_RESP_OKAY      2'h0
`define IOPC_RESP_SLVERR    2'h2
`endif

// ===== hdl/iopc_pkg.sv
// Types for the interrupt option and low-power control block
package iopc_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_STOP, ST_STAB} iopc_pwr_t;
  typedef enum logic [1:0] {CTX_MAIN, CTX_IRQ, CTX_NMI} iopc_ctx_t;
  // Peripheral and pin event inputs
  typedef struct packed {
    logic       nmi_line;
    logic       src1_line;
    logic       src2_line;
    logic       timer_overflow_flag;
    logic       timer_interrupt_mask;
    logic       converter_eoc_flag;
    logic       converter_interrupt_mask;
    logic       reload_overflow_flag;
    logic       reload_overflow_enable;
    logic       compare_match_flag;
    logic       compare_match_enable;
    logic       input_edge_flag;
    logic       input_edge_enable;
  } iopc_events_t;
  // Core sequencing inputs
  typedef struct packed {
    logic       instr_end;
    logic       wait_exec;
    logic       stop_exec;
    logic       watchdog_active;
    logic       irq_enter;
    logic       nmi_enter;
    logic       reti;
  } iopc_core_in_t;
  // Core facing outputs
  typedef struct packed {
    logic [4:0] vec_req;
    logic       halt;
    logic       osc_stop;
    logic       take_irq;
    logic       skip_halt;
  } iopc_core_out_t;
  // Whole block state
  typedef struct packed {
    logic [7:0] mode_cfg;
    logic       nmi_latch;
    logic       src1_latch;
    logic       src2_latch;
    logic       src1_prev;
    logic       src2_prev;
    logic       nmi_prev;
    iopc_pwr_t  pwr;
    iopc_ctx_t  ctx;
    iopc_ctx_t  ctx_save;
    logic [15:0] stab_cnt;
    logic [15:0] stab_len;
    logic       wdg_sw_en;
    logic       wake_seen;
    logic       awvalid_seen;
    logic [7:0] awaddr;
    logic       wvalid_seen;
    logic [7:0] wdata;
    logic       bvalid;
    logic [1:0] bresp;
    logic       rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } iopc_state_t;
endpackage

// ===== hdl/iopc_ctrl.sv
// Interrupt option register, vector routing and WAIT/STOP control
`timescale 1ns/10ps
`default_nettype none
`include "iopc_cfg.svh"

// Notes on behaviour
// RULE_01: Mode register at 0C8h, byte writes only, reset to 00h.
// RULE_02: Bit 7 and bits 3 to 0 have no function.
// RULE_03: Level-select one makes source 1 level sensitive, zero edge.
// RULE_04: Edge-polarity bit picks the active edge of source 2.
// RULE_05: Polarity one means rising edges, zero means falling edges.
// RULE_06: Global enable set enables all; clear disables all except non-maskable.
// RULE_07: Global enable clear: non-maskable still serviced but never wakes.
// RULE_08: Edge latch set by edge, cleared at routine start, first edge kept.
// RULE_09: Masked timer overflow and converter end request vector 4.
// RULE_10: Enabled reload overflow, compare, input edge request vector 3.
// RULE_11: Ports A and B request vector 1, port C vector 2.
// RULE_12: WAIT halts instructions, oscillator and peripherals keep running.
// RULE_13: Interrupt wake from WAIT adds no stabilisation delay.
// RULE_14: STOP halts and stops oscillator, waits interrupt or reset.
// RULE_15: With watchdog active, STOP acts as WAIT.
// RULE_16: Wake from STOP holds off first instruction for stabilisation delay.
// RULE_17: Reset during WAIT or STOP starts normal reset sequence.
// RULE_18: From main routine, waking interrupt is serviced first.
// RULE_19: From non-maskable routine, wake resumes next instruction, no service.
// RULE_20: From normal routine, normal wake continues routine; pending later.
// RULE_21: From normal routine, non-maskable wake is serviced first.
// RULE_22: WAIT or STOP skipped when enabled request already pending.
// RULE_23: Wake-up leaves the oscillator selection unchanged.
// RULE_24: Reads of the mode register return zero, contents untouched.
module iopc_ctrl (
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire iopc_pkg::iopc_events_t  events,
  input  wire logic [7:0]             port_a_irq,
  input  wire logic [7:0]             port_b_irq,
  input  wire logic [7:0]             port_c_irq,
  input  wire iopc_pkg::iopc_core_in_t core_in,
  output iopc_pkg::iopc_core_out_t     core_out
);

  // ----------------------------------------------------------------
  // State and combinational helpers
  // ----------------------------------------------------------------
  iopc_pkg::iopc_state_t q;
  iopc_pkg::iopc_state_t d;
  logic       gen_en;
  logic       src1_req;
  logic [4:0] req;
  logic       maskable_pend;
  logic       wake;
  logic       wr_go;
  logic       rd_go;

  // Reads return a register image; mode register is write-only
  function automatic logic [31:0] rd_image(input logic [7:0] a, input iopc_pkg::iopc_state_t s);
    rd_image = 32'h0000_0000;
    case (a)
      `IOPC_ADDR_MODE_CFG: rd_image = 32'h0000_0000; // [RULE_24]
      `IOPC_ADDR_CORE_CTL: rd_image = {31'h0000_0000, s.wdg_sw_en};
      `IOPC_ADDR_STATUS:   rd_image = {24'h00_0000, s.ctx, s.pwr, s.nmi_latch,
                                       s.src1_latch, s.src2_latch, s.wake_seen};
      `IOPC_ADDR_STAB:     rd_image = {16'h0000, s.stab_len};
      default:             rd_image = 32'h0000_0000;
    endcase
  endfunction

  // Known address check, used by both channels
  function automatic logic addr_ok(input logic [7:0] a);
    addr_ok = (a == `IOPC_ADDR_MODE_CFG) || (a == `IOPC_ADDR_CORE_CTL) ||
              (a == `IOPC_ADDR_STATUS) || (a == `IOPC_ADDR_STAB);
  endfunction

  // ----------------------------------------------------------------
  // Request routing
  // ----------------------------------------------------------------
  always_comb begin
    gen_en   = q.mode_cfg[`IOPC_BIT_GLOBAL_EN];
    // Level mode follows the low line directly, edge mode uses the latch
    src1_req = q.mode_cfg[`IOPC_BIT_LEVEL] ? ~events.src1_line : q.src1_latch; // [RULE_03]
    req[0]   = q.nmi_latch;
    req[1]   = src1_req | (|port_a_irq) | (|port_b_irq); // [RULE_11]
    req[2]   = q.src2_latch | (|port_c_irq); // [RULE_11]
    req[3]   = (events.reload_overflow_flag & events.reload_overflow_enable) |
               (events.compare_match_flag & events.compare_match_enable) |
               (events.input_edge_flag & events.input_edge_enable); // [RULE_10]
    req[4]   = (events.timer_overflow_flag & events.timer_interrupt_mask) |
               (events.converter_eoc_flag & events.converter_interrupt_mask); // [RULE_09]
    maskable_pend = gen_en & (|req[4:1]); // [RULE_06]
    // Only an enabled request wakes; the non-maskable one needs enable too
    wake     = gen_en & (|req); // [RULE_07]
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    s_axi_awready = ~q.awvalid_seen & ~q.bvalid;
    s_axi_wready  = ~q.wvalid_seen & ~q.bvalid;
    s_axi_arready = ~q.rvalid;
    wr_go = 1'b0;
    rd_go = s_axi_arvalid & s_axi_arready;
    core_out.vec_req   = {req[4:1] & {4{gen_en}}, req[0]}; // [RULE_06]
    core_out.halt      = (q.pwr != iopc_pkg::ST_RUN); // [RULE_12]
    core_out.osc_stop  = (q.pwr == iopc_pkg::ST_STOP); // [RULE_14]
    core_out.skip_halt = (core_in.wait_exec | core_in.stop_exec) &
                         (maskable_pend | q.nmi_latch); // [RULE_22]
    core_out.take_irq  = 1'b0;

    // Write channel capture
    if (s_axi_awvalid & s_axi_awready) begin
      d.awvalid_seen = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid & s_axi_wready) begin
      d.wvalid_seen = 1'b1;
      d.wdata = s_axi_wdata[7:0];
      // With byte lane 0 strobe clear the write still lands, but stores zero
      if (!s_axi_wstrb[0]) begin
        d.wdata = 8'h00;
      end
    end
    if (d.awvalid_seen & d.wvalid_seen & ~q.bvalid) begin
      wr_go = 1'b1;
      d.awvalid_seen = 1'b0;
      d.wvalid_seen = 1'b0;
      d.bvalid = 1'b1;
      d.bresp = addr_ok(d.awaddr) ? `IOPC_RESP_OKAY : `IOPC_RESP_SLVERR;
      case (d.awaddr)
        `IOPC_ADDR_MODE_CFG: d.mode_cfg = d.wdata & `IOPC_MODE_USED_MASK; // [RULE_01] [RULE_02]
        `IOPC_ADDR_CORE_CTL: d.wdg_sw_en = d.wdata[0];
        `IOPC_ADDR_STAB:     d.stab_len = {8'h00, d.wdata};
        default: ;
      endcase
    end
    if (q.bvalid & s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    if (rd_go) begin
      d.rvalid = 1'b1;
      d.rdata  = rd_image(s_axi_araddr, q);
      d.rresp  = addr_ok(s_axi_araddr) ? `IOPC_RESP_OKAY : `IOPC_RESP_SLVERR;
    end else if (q.rvalid & s_axi_rready) begin
      d.rvalid = 1'b0;
    end

    // Edge detectors; a latch holds only the first edge until service
    d.src1_prev = events.src1_line;
    d.src2_prev = events.src2_line;
    d.nmi_prev  = events.nmi_line;
    if (q.nmi_prev & ~events.nmi_line) begin
      d.nmi_latch = 1'b1;
    end else if (core_in.nmi_enter) begin
      d.nmi_latch = 1'b0;
    end
    if (q.src1_prev & ~events.src1_line & ~q.mode_cfg[`IOPC_BIT_LEVEL]) begin
      d.src1_latch = 1'b1; // [RULE_08]
    end else if (core_in.irq_enter | q.mode_cfg[`IOPC_BIT_LEVEL]) begin
      d.src1_latch = 1'b0; // [RULE_08]
    end
    if (q.mode_cfg[`IOPC_BIT_EDGE_POL] ? (~q.src2_prev & events.src2_line)
                                       : (q.src2_prev & ~events.src2_line)) begin
      d.src2_latch = 1'b1; // [RULE_04] [RULE_05]
    end else if (core_in.irq_enter) begin
      d.src2_latch = 1'b0;
    end

    // Routine context tracking
    if (core_in.nmi_enter) begin
      d.ctx_save = q.ctx;
      d.ctx = iopc_pkg::CTX_NMI;
    end else if (core_in.irq_enter) begin
      d.ctx = iopc_pkg::CTX_IRQ;
    end else if (core_in.reti) begin
      d.ctx = (q.ctx == iopc_pkg::CTX_NMI) ? q.ctx_save : iopc_pkg::CTX_MAIN;
    end

    // Halting instruction clears the wake flag; a wake in the same cycle wins
    if (core_in.wait_exec | core_in.stop_exec) begin
      d.wake_seen = 1'b0;
    end
    // Power state sequencing; oscillator selection is never touched here
    case (q.pwr)
      iopc_pkg::ST_RUN: begin
        if (!core_out.skip_halt) begin
          if (core_in.stop_exec & ~core_in.watchdog_active & ~q.wdg_sw_en) begin
            d.pwr = iopc_pkg::ST_STOP; // [RULE_14]
          end else if (core_in.wait_exec | core_in.stop_exec) begin
            d.pwr = iopc_pkg::ST_WAIT; // [RULE_15]
          end
        end
        // Service decision: NMI outside its own routine, maskable only from main
        core_out.take_irq = core_in.instr_end &
                            ((q.nmi_latch & (q.ctx != iopc_pkg::CTX_NMI)) |
                             (maskable_pend & (q.ctx == iopc_pkg::CTX_MAIN))); // [RULE_19]
      end
      iopc_pkg::ST_WAIT: begin
        if (wake) begin
          d.pwr = iopc_pkg::ST_RUN; // [RULE_13]
          d.wake_seen = 1'b1;
        end
      end
      iopc_pkg::ST_STOP: begin
        if (wake) begin
          d.pwr = iopc_pkg::ST_STAB; // [RULE_16]
          d.stab_cnt = q.stab_len;
          d.wake_seen = 1'b1;
        end
      end
      iopc_pkg::ST_STAB: begin
        if (q.stab_cnt <= 16'h0001) begin
          d.pwr = iopc_pkg::ST_RUN; // [RULE_16] [RULE_23]
        end else begin
          d.stab_cnt = q.stab_cnt - 16'h0001;
        end
      end
      default: d.pwr = iopc_pkg::ST_RUN;
    endcase
    // Service selection on wake follows the prior context
    if (q.pwr != iopc_pkg::ST_RUN && d.pwr == iopc_pkg::ST_RUN) begin
      case (q.ctx)
        iopc_pkg::CTX_MAIN: core_out.take_irq = 1'b1; // [RULE_18]
        iopc_pkg::CTX_NMI:  core_out.take_irq = 1'b0; // [RULE_19]
        iopc_pkg::CTX_IRQ:  core_out.take_irq = q.nmi_latch; // [RULE_20] [RULE_21]
        default:            core_out.take_irq = 1'b0;
      endcase
    end
    s_axi_bvalid = q.bvalid;
    s_axi_bresp  = q.bresp;
    s_axi_rvalid = q.rvalid;
    s_axi_rdata  = q.rdata;
    s_axi_rresp  = q.rresp;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      q <= '0; // [RULE_17]
      q.mode_cfg <= `IOPC_MODE_RESET; // [RULE_01]
      q.stab_len <= `IOPC_STAB_DEFAULT;
      q.src1_prev <= 1'b1;
      q.src2_prev <= 1'b1;
      q.nmi_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_mode_reset: assert property (@(posedge clock) // [RULE_01]
    sys_rst |=> q.mode_cfg == `IOPC_MODE_RESET)
    else $error("mode register not cleared by reset");
  a_unused_bits: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_02]
    (q.mode_cfg & ~`IOPC_MODE_USED_MASK) == 8'h00)
    else $error("unused mode bits stored");
  a_mode_read: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_24]
    rd_go && !wr_go && s_axi_araddr == `IOPC_ADDR_MODE_CFG
    |=> s_axi_rdata == 32'h0000_0000 && $stable(q.mode_cfg))
    else $error("mode register read not zero");
  a_vec_mask: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_06]
    !q.mode_cfg[`IOPC_BIT_GLOBAL_EN] |-> core_out.vec_req[4:1] == 4'h0)
    else $error("maskable vector with enable clear");
  a_vec4_route: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_09]
    q.mode_cfg[`IOPC_BIT_GLOBAL_EN] && events.timer_overflow_flag &&
    events.timer_interrupt_mask |-> core_out.vec_req[4])
    else $error("timer overflow not on vector 4");
  a_vec3_route: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_10]
    q.mode_cfg[`IOPC_BIT_GLOBAL_EN] && events.compare_match_flag &&
    events.compare_match_enable |-> core_out.vec_req[3])
    else $error("compare match not on vector 3");
  a_port_route: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_11]
    q.mode_cfg[`IOPC_BIT_GLOBAL_EN] && (|port_c_irq) |-> core_out.vec_req[2])
    else $error("port c pin not on vector 2");
  a_src1_level: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_03]
    q.mode_cfg[`IOPC_BIT_GLOBAL_EN] && q.mode_cfg[`IOPC_BIT_LEVEL] && !events.src1_line
    |-> core_out.vec_req[1])
    else $error("low level on source 1 not requested");
  a_src2_rise: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_05]
    q.mode_cfg[`IOPC_BIT_EDGE_POL] && !q.src2_prev && events.src2_line |=> q.src2_latch)
    else $error("rising edge on source 2 not latched");
  a_nowake_off: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_07]
    q.pwr == iopc_pkg::ST_WAIT && !q.mode_cfg[`IOPC_BIT_GLOBAL_EN]
    |=> q.pwr == iopc_pkg::ST_WAIT)
    else $error("woke with enable clear");
  a_wait_halt: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_12]
    q.pwr == iopc_pkg::ST_RUN && core_in.wait_exec && !core_in.stop_exec &&
    !core_out.skip_halt |=> core_out.halt && !core_out.osc_stop)
    else $error("wait did not halt with oscillator running");
  a_wait_wake: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_13]
    q.pwr == iopc_pkg::ST_WAIT && wake |=> q.pwr == iopc_pkg::ST_RUN)
    else $error("wait wake delayed");
  a_stop_osc: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_14]
    q.pwr == iopc_pkg::ST_RUN && core_in.stop_exec && !core_in.watchdog_active &&
    !q.wdg_sw_en && !core_out.skip_halt |=> core_out.osc_stop)
    else $error("stop did not stop the oscillator");
  sequence s_stop_wake;
    q.pwr == iopc_pkg::ST_STOP && wake;
  endsequence
  a_stop_stab: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_16]
    s_stop_wake |=> q.pwr == iopc_pkg::ST_STAB [*1] ##1 q.pwr != iopc_pkg::ST_STOP)
    else $error("stop wake skipped stabilisation");
  a_stop_as_wait: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_15]
    q.pwr == iopc_pkg::ST_RUN && core_in.stop_exec && core_in.watchdog_active
    |=> q.pwr != iopc_pkg::ST_STOP)
    else $error("stop entered with watchdog on");
  a_skip_pend: assert property (@(posedge clock) disable iff (sys_rst) // [RULE_22]
    q.pwr == iopc_pkg::ST_RUN && core_out.skip_halt |=> q.pwr == iopc_pkg::ST_RUN)
    else $error("halt entered with request pending");

endmodule
`default_nettype wire

// ===== tb/iopc_core_model.sv
// Behavioural model of the processor core that sequences the block
`timescale 1ns/10ps
`default_nettype none
module iopc_core_model (
  input  wire logic                     clock,
  input  wire logic                     sys_rst,
  input  wire logic                     req_wait,
  input  wire logic                     req_stop,
  input  wire logic                     wdg_on,
  input  wire iopc_pkg::iopc_core_out_t core_out,
  output var  iopc_pkg::iopc_core_in_t  core_in
);
  // ----------------------------------------
  // Instruction flow and routine entry
  // ----------------------------------------
  // Instructions end only while not halted; a take_irq pulse opens a routine
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      core_in <= '0;
    end else begin
      core_in.instr_end       <= !core_out.halt;
      core_in.wait_exec       <= req_wait;
      core_in.stop_exec       <= req_stop;
      core_in.watchdog_active <= wdg_on;
      core_in.irq_enter       <= core_out.take_irq & ~core_out.vec_req[0];
      core_in.nmi_enter       <= core_out.take_irq & core_out.vec_req[0];
      core_in.reti            <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for the interrupt option and low-power control block
`timescale 1ns/10ps
`default_nettype none
module tb;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic                     clock, sys_rst;
  logic [7:0]               awaddr, araddr, pa, pb, pc;
  logic [31:0]              wdata, rdata, s;
  logic                     awvalid, awready, wvalid, wready, bvalid, bready;
  logic                     arvalid, arready, rvalid, rready, req_wait, req_stop, wdg_on;
  logic [1:0]               bresp, rresp;
  logic [3:0]               wstrb;
  iopc_pkg::iopc_events_t   ev;
  iopc_pkg::iopc_core_in_t  core_in;
  iopc_pkg::iopc_core_out_t core_out;
  logic [1:0]               bq[$];
  logic [33:0]              rq[$];
  int                       failures, checks;
  int                       vt[8] = '{4, 4, 3, 3, 3, 1, 1, 2};

  iopc_ctrl dut_u (.clock(clock), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .events(ev), .port_a_irq(pa), .port_b_irq(pb),
    .port_c_irq(pc), .core_in(core_in), .core_out(core_out));
  iopc_core_model core_u (.clock(clock), .sys_rst(sys_rst), .req_wait(req_wait),
    .req_stop(req_stop), .wdg_on(wdg_on), .core_out(core_out), .core_in(core_in));

  // ----------------------------------------
  // Compare, stimulus and bus tasks
  // ----------------------------------------
  task automatic chk_bus(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_sig(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  function automatic logic [31:0] xs();
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic rst_dut();
    sys_rst <= 1'b1;
    step(12);
    sys_rst <= 1'b0;
    step(1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    bq.push_back(r);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(ta && tw)) begin
      @(posedge clock);
      if ((awvalid & awready) === 1'b1) begin
        ta = 1'b1;
        awvalid <= 1'b0;
      end
      if ((wvalid & wready) === 1'b1) begin
        tw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clock); while (bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge clock); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clock); while (rvalid !== 1'b1);
  endtask
  // One event source per index; masks follow m, port pins need both
  task automatic set_src(input int i, input logic f, input logic m);
    logic [2:0] p;
    p = 3'(xs());
    ev.timer_overflow_flag <= f && i == 0;
    ev.timer_interrupt_mask <= m;
    ev.converter_eoc_flag <= f && i == 1;
    ev.converter_interrupt_mask <= m;
    ev.reload_overflow_flag <= f && i == 2;
    ev.reload_overflow_enable <= m;
    ev.compare_match_flag <= f && i == 3;
    ev.compare_match_enable <= m;
    ev.input_edge_flag <= f && i == 4;
    ev.input_edge_enable <= m;
    pa <= (f && m && i == 5) ? 8'h01 << p : 8'h00;
    pb <= (f && m && i == 6) ? 8'h01 << p : 8'h00;
    pc <= (f && m && i == 7) ? 8'h01 << p : 8'h00;
  endtask
  task automatic halt_is(input logic e, input int lim);
    int n;
    n = 0;
    while (core_out.halt !== e && n < lim) begin
      step(1);
      n++;
    end
    chk_sig("halt", {7'h0, e}, {7'h0, core_out.halt});
  endtask
  task automatic pulse(input logic st);
    req_wait <= !st;
    req_stop <= st;
    step(1);
    req_wait <= 1'b0;
    req_stop <= 1'b0;
  endtask
  task automatic report_and_stop();
    $display("Checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------
  // Clock, response monitor and watchdog
  // ----------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // Oldest expected response is taken off its queue at each handshake
  always @(posedge clock) begin
    if ((bvalid & bready) === 1'b1) chk_bus("bresp", {30'h0, bq.pop_front()}, {30'h0, bresp});
    if ((rvalid & rready) === 1'b1) begin
      chk_bus("rresp", {30'h0, rq[0][33:32]}, {30'h0, rresp});
      if (rq[0][33:32] == 2'h0) chk_bus("rdata", rq[0][31:0], rdata);
      void'(rq.pop_front());
    end
  end
  initial begin
    step(20000);
    failures++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    s = 32'd59;
    {awaddr, araddr, wdata, awvalid, wvalid, arvalid} = '0;
    // Response channels stay ready for the whole run
    {bready, rready} = 2'b11;
    {req_wait, req_stop, wdg_on, pa, pb, pc} = '0;
    wstrb = 4'hf;
    ev = '0;
    ev.nmi_line = 1'b1;
    ev.src1_line = 1'b1;
    ev.src2_line = 1'b1;
    rst_dut();
    rd(8'hc8, {2'h0, 32'h0});
    rd(8'h40, {2'h2, 32'h0});
    wr(8'h40, 8'h55, 2'h2);
    // Reserved bits carry random values and must change nothing
    wr(8'hc8, (8'(xs()) & 8'h8f) | 8'h10, 2'h0);
    rd(8'hc8, {2'h0, 32'h0});
    for (int i = 0; i < 8; i++) begin
      set_src(i, 1'b1, 1'b0);
      step(2);
      chk_sig("vec_off", 8'h0, {4'h0, core_out.vec_req[4:1]});
      set_src(i, 1'b1, 1'b1);
      step(2);
      chk_sig("vec_on", 8'h1 << (vt[i] - 1), {4'h0, core_out.vec_req[4:1]});
    end
    wr(8'hc8, 8'h00, 2'h0);
    step(2);
    chk_sig("vec_gen0", 8'h0, {4'h0, core_out.vec_req[4:1]});
    set_src(0, 1'b0, 1'b0);
    // Source 2 polarity, then source 1 level and edge modes
    rst_dut();
    wr(8'hc8, 8'h30, 2'h0);
    ev.src2_line <= 1'b0;
    step(2);
    chk_sig("src2_fall", 8'h0, {7'h0, core_out.vec_req[2]});
    ev.src2_line <= 1'b1;
    step(2);
    chk_sig("src2_rise", 8'h1, {7'h0, core_out.vec_req[2]});
    rst_dut();
    chk_sig("src2_rst", 8'h0, {7'h0, core_out.vec_req[2]});
    wr(8'hc8, 8'h50, 2'h0);
    ev.src1_line <= 1'b0;
    step(2);
    chk_sig("src1_low", 8'h1, {7'h0, core_out.vec_req[1]});
    ev.src1_line <= 1'b1;
    step(2);
    chk_sig("src1_high", 8'h0, {7'h0, core_out.vec_req[1]});
    wr(8'hc8, 8'h10, 2'h0);
    ev.src1_line <= 1'b0;
    step(2);
    ev.src1_line <= 1'b1;
    step(2);
    chk_sig("src1_edge", 8'h1, {7'h0, core_out.vec_req[1]});
    // WAIT, STOP and STOP demoted by the watchdog
    rst_dut();
    wr(8'hc8, 8'h10, 2'h0);
    pulse(1'b0);
    halt_is(1'b1, 5);
    chk_sig("osc_wait", 8'h0, {7'h0, core_out.osc_stop});
    set_src(0, 1'b1, 1'b1);
    halt_is(1'b0, 3);
    set_src(0, 1'b0, 1'b0);
    step(4);
    pulse(1'b1);
    halt_is(1'b1, 5);
    chk_sig("osc_stop", 8'h1, {7'h0, core_out.osc_stop});
    set_src(2, 1'b1, 1'b1);
    step(100);
    chk_sig("stab_hold", 8'h1, {7'h0, core_out.halt});
    halt_is(1'b0, 300);
    chk_sig("osc_back", 8'h0, {7'h0, core_out.osc_stop});
    set_src(0, 1'b0, 1'b0);
    wdg_on <= 1'b1;
    step(4);
    pulse(1'b1);
    halt_is(1'b1, 5);
    chk_sig("osc_wdg", 8'h0, {7'h0, core_out.osc_stop});
    set_src(7, 1'b1, 1'b1);
    halt_is(1'b0, 3);
    wdg_on <= 1'b0;
    pulse(1'b0);
    repeat (4) begin
      step(1);
      chk_sig("skip", 8'h0, {7'h0, core_out.halt});
    end
    set_src(0, 1'b0, 1'b0);
    // Global enable clear: the non-maskable line cannot wake
    wr(8'hc8, 8'h00, 2'h0);
    pulse(1'b0);
    halt_is(1'b1, 5);
    ev.nmi_line <= 1'b0;
    step(10);
    chk_sig("nmi_latch", 8'h1, {7'h0, core_out.vec_req[0]});
    chk_sig("nmi_nowake", 8'h1, {7'h0, core_out.halt});
    ev.nmi_line <= 1'b1;
    rst_dut();
    chk_sig("rst_wake", 8'h0, {7'h0, core_out.halt});
    report_and_stop();
  end
endmodule
`default_nettype wire
